//--- rtl/chgs_pkg.sv
// constants for the charger setting register bank
package chgs_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] OFS_TIMER_MASK   = 8'h0C;
    localparam logic [7:0] OFS_BOOST_MASK   = 8'h0D;
    localparam logic [7:0] OFS_VBAT_TARGET  = 8'h0E;
    localparam logic [7:0] OFS_CHG_CURRENT  = 8'h0F;
    localparam logic [7:0] OFS_WEAK_INLIM   = 8'h10;
    localparam logic [7:0] OFS_ADAPTER_LIM  = 8'h11;
    localparam logic [7:0] OFS_EVT_STATUS   = 8'h12;
    localparam logic [7:0] OFS_EVT_MASK     = 8'h13;

    // writable bit masks, reserved bits excluded
    localparam logic [7:0] WMASK_TIMER      = 8'h02;
    localparam logic [7:0] WMASK_BOOST      = 8'h1F;
    localparam logic [7:0] WMASK_VBAT       = 8'h3F;
    localparam logic [7:0] WMASK_CHG        = 8'hFF;
    localparam logic [7:0] WMASK_WEAK       = 8'h7F;
    localparam logic [7:0] WMASK_ADAPTER    = 8'hF0;
    localparam logic [7:0] WMASK_EVT        = 8'h3F;

    // reset values
    localparam logic [7:0] RST_TIMER_MASK   = 8'h02;
    localparam logic [7:0] RST_BOOST_MASK   = 8'h1F;
    localparam logic [7:0] RST_VBAT_TARGET  = 8'h0C;
    localparam logic [7:0] RST_CHG_CURRENT  = 8'h26;
    localparam logic [7:0] RST_WEAK_INLIM   = 8'h2C;
    localparam logic [7:0] RST_ADAPTER_LIM  = 8'h00;
    localparam logic [7:0] RST_EVT_MASK     = 8'h00;

    // field positions
    localparam int CHG_EXT_BIT   = 7;
    localparam int EOC_LSB       = 4;
    localparam int WEAK_LSB      = 5;
    localparam int RECON_LSB     = 2;
    localparam int ADAPTER_LSB   = 4;
    localparam int TIMER_MASK_BIT = 1;
    localparam int NUM_EVT       = 6;

    // decode scales: voltages in mV, currents in mA
    localparam logic [12:0] VBAT_BASE_MV  = 13'd3300;
    localparam logic [12:0] VBAT_STEP_UV  = 13'd25;
    localparam logic [12:0] FAST_CHARGE_CURRENT_CODE_BASE_MA  = 13'd450;
    localparam logic [12:0] FAST_CHARGE_CURRENT_CODE_STEP_MA  = 13'd100;
    localparam logic [12:0] FAST_CHARGE_CURRENT_CODE_EXT_MA   = 13'd1600;
    localparam logic [12:0] END_OF_CHARGE_THRESHOLD_BASE_MA  = 13'd100;
    localparam logic [12:0] END_OF_CHARGE_THRESHOLD_STEP_MA  = 13'd25;
    localparam logic [12:0] WEAK_BATTERY_CURRENT_STEP_MA = 13'd100;
    localparam logic [12:0] RECON_BASE_MV = 13'd3100;
    localparam logic [12:0] RECON_STEP_MV = 13'd100;
    localparam logic [12:0] RECON_MAX_MV  = 13'd3600;
    localparam logic [12:0] ITA_BASE_MA   = 13'd500;
    localparam logic [12:0] ITA_STEP_MA   = 13'd100;
    localparam logic [12:0] IIN_00_MA     = 13'd100;
    localparam logic [12:0] IIN_01_MA     = 13'd500;
    localparam logic [12:0] IIN_10_MA     = 13'd900;
    localparam logic [12:0] IIN_11_MA     = 13'd1500;
endpackage

//--- rtl/chgs_decode.sv
// decodes register codes into physical set points for the charge loop
`timescale 1ns/1ps
`default_nettype none
module chgs_decode (
    // register codes
    input  wire logic [5:0]  vbat_code,
    input  wire logic [3:0]  fast_charge_current_code,
    input  wire logic        charge_current_range_extend,
    input  wire logic [2:0]  end_of_charge_threshold,
    input  wire logic [1:0]  weak_battery_current,
    input  wire logic [2:0]  reconnect_threshold,
    input  wire logic [1:0]  input_limit_code,
    input  wire logic [3:0]  adapter_limit_code,
    // decoded set points
    output logic      [12:0] vbat_mv,
    output logic      [12:0] fast_charge_current_code_ma,
    output logic      [12:0] end_of_charge_threshold_ma,
    output logic      [12:0] weak_battery_current_ma,
    output logic      [12:0] recon_mv,
    output logic      [12:0] iin_ma
);
    // two-bit input limit table, used only while the adapter limit code is zero
    function automatic logic [12:0] usb_limit(input logic [1:0] c);
        case (c)
            2'h0:    usb_limit = chgs_pkg::IIN_00_MA;
            2'h1:    usb_limit = chgs_pkg::IIN_01_MA;
            2'h2:    usb_limit = chgs_pkg::IIN_10_MA;
            default: usb_limit = chgs_pkg::IIN_11_MA;
        endcase
    endfunction

    // linear decodes; 25 mV steps done as 25*code in mV
    always_comb
    begin
        vbat_mv  = chgs_pkg::VBAT_BASE_MV + 13'(vbat_code) * chgs_pkg::VBAT_STEP_UV;
        fast_charge_current_code_ma  = chgs_pkg::FAST_CHARGE_CURRENT_CODE_BASE_MA
                 + 13'(fast_charge_current_code) * chgs_pkg::FAST_CHARGE_CURRENT_CODE_STEP_MA;
        if (charge_current_range_extend)
            fast_charge_current_code_ma = fast_charge_current_code_ma + chgs_pkg::FAST_CHARGE_CURRENT_CODE_EXT_MA;
        end_of_charge_threshold_ma  = chgs_pkg::END_OF_CHARGE_THRESHOLD_BASE_MA
                 + 13'(end_of_charge_threshold) * chgs_pkg::END_OF_CHARGE_THRESHOLD_STEP_MA;
        weak_battery_current_ma = 13'(weak_battery_current) * chgs_pkg::WEAK_BATTERY_CURRENT_STEP_MA;
        recon_mv = chgs_pkg::RECON_BASE_MV
                 + 13'(reconnect_threshold) * chgs_pkg::RECON_STEP_MV;
        // codes above 101 are undefined; clamp at the top threshold
        if (recon_mv > chgs_pkg::RECON_MAX_MV)
            recon_mv = chgs_pkg::RECON_MAX_MV;
        if (adapter_limit_code == 4'h0)
            iin_ma = usb_limit(input_limit_code);
        else
            iin_ma = chgs_pkg::ITA_BASE_MA
                   + 13'(adapter_limit_code) * chgs_pkg::ITA_STEP_MA;
    end
endmodule
`default_nettype wire

//--- rtl/chgs_regs.sv
// charger setting register bank with event mask and interrupt
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module chgs_regs (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // default-restoring conditions, pins from the power domain
    input  wire logic        OFF_STATE,
    input  wire logic        REG_RESET_CMD,
    input  wire logic        BOOST_HOST_MODE,
    // events: [5] charge timer, [4:0] booster events, pins
    input  wire logic [5:0]  EVT_IN,
    // decoded set points
    output logic      [12:0] VBAT_MV,
    output logic      [12:0] FAST_CHARGE_CURRENT_CODE_MA,
    output logic      [12:0] END_OF_CHARGE_THRESHOLD_MA,
    output logic      [12:0] WEAK_BATTERY_CURRENT_MA,
    output logic      [12:0] RECON_MV,
    output logic      [12:0] IIN_MA,
    // interrupt
    output logic             IRQ
);
    // registers
    logic [7:0] timer_mask_reg;
    logic [7:0] boost_mask_reg;
    logic [7:0] vbat_reg;
    logic [7:0] chg_reg;
    logic [7:0] weak_reg;
    logic [7:0] adapter_reg;
    logic [7:0] evt_status_reg;
    logic [7:0] evt_mask_reg;
    logic [7:0] evt_status_next;

    // synchronisers for pin inputs
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic [5:0] evt_prev_reg;
    logic       boost_prev_reg;
    logic       defaults;
    logic       boost_entry;
    logic [5:0] evt_rise;
    logic [5:0] evt_gate;

    // two flops before use; first stage read only by the second
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end
        else
        begin
            sync1_reg <= {OFF_STATE, REG_RESET_CMD, BOOST_HOST_MODE, EVT_IN};
            sync2_reg <= sync1_reg;
        end
    end

    // edge history for boost entry and event pulses
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            evt_prev_reg   <= 6'h00;
            boost_prev_reg <= 1'b0;
        end
        else
        begin
            evt_prev_reg   <= sync2_reg[5:0];
            boost_prev_reg <= sync2_reg[6];
        end
    end

    assign boost_entry = sync2_reg[6] & ~boost_prev_reg;
    // off state and reset command hold defaults; boost reloads on entry only
    assign defaults    = sync2_reg[8] | sync2_reg[7] | boost_entry;
    assign evt_rise    = sync2_reg[5:0] & ~evt_prev_reg;

    // write decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // setting and mask registers; reserved bits never stored
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST || defaults)
        begin
            timer_mask_reg <= chgs_pkg::RST_TIMER_MASK;
            boost_mask_reg <= chgs_pkg::RST_BOOST_MASK;
            vbat_reg       <= chgs_pkg::RST_VBAT_TARGET;
            chg_reg        <= chgs_pkg::RST_CHG_CURRENT;
            weak_reg       <= chgs_pkg::RST_WEAK_INLIM;
            adapter_reg    <= chgs_pkg::RST_ADAPTER_LIM;
            evt_mask_reg   <= chgs_pkg::RST_EVT_MASK;
        end
        else if (REG_WR)
        begin
            if (hit(REG_ADDR, chgs_pkg::OFS_TIMER_MASK))
                timer_mask_reg <= REG_WDATA & chgs_pkg::WMASK_TIMER;
            if (hit(REG_ADDR, chgs_pkg::OFS_BOOST_MASK))
                boost_mask_reg <= REG_WDATA & chgs_pkg::WMASK_BOOST;
            if (hit(REG_ADDR, chgs_pkg::OFS_VBAT_TARGET))
                vbat_reg       <= REG_WDATA & chgs_pkg::WMASK_VBAT;
            if (hit(REG_ADDR, chgs_pkg::OFS_CHG_CURRENT))
                chg_reg        <= REG_WDATA & chgs_pkg::WMASK_CHG;
            if (hit(REG_ADDR, chgs_pkg::OFS_WEAK_INLIM))
                weak_reg       <= REG_WDATA & chgs_pkg::WMASK_WEAK;
            if (hit(REG_ADDR, chgs_pkg::OFS_ADAPTER_LIM))
                adapter_reg    <= REG_WDATA & chgs_pkg::WMASK_ADAPTER;
            if (hit(REG_ADDR, chgs_pkg::OFS_EVT_MASK))
                evt_mask_reg   <= REG_WDATA & chgs_pkg::WMASK_EVT;
        end
    end

    // events are gated by both the documented masks and the general mask
    assign evt_gate = ~({timer_mask_reg[chgs_pkg::TIMER_MASK_BIT], boost_mask_reg[4:0]}
                        | evt_mask_reg[5:0]);

    // sticky status: write one clears, a new event wins over the clear
    always_comb
    begin
        evt_status_next = evt_status_reg;
        if (REG_WR && hit(REG_ADDR, chgs_pkg::OFS_EVT_STATUS))
            evt_status_next = evt_status_next & ~(REG_WDATA & chgs_pkg::WMASK_EVT);
        evt_status_next = evt_status_next | {2'b00, evt_rise};
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            evt_status_reg <= 8'h00;
        else
            evt_status_reg <= evt_status_next;
    end

    // interrupt level from a flop, updated on the same edge as status
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(evt_status_next[5:0] & evt_gate);
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                chgs_pkg::OFS_TIMER_MASK:  REG_RDATA <= timer_mask_reg;
                chgs_pkg::OFS_BOOST_MASK:  REG_RDATA <= boost_mask_reg;
                chgs_pkg::OFS_VBAT_TARGET: REG_RDATA <= vbat_reg;
                chgs_pkg::OFS_CHG_CURRENT: REG_RDATA <= chg_reg;
                chgs_pkg::OFS_WEAK_INLIM:  REG_RDATA <= weak_reg;
                chgs_pkg::OFS_ADAPTER_LIM: REG_RDATA <= adapter_reg;
                chgs_pkg::OFS_EVT_STATUS:  REG_RDATA <= evt_status_reg;
                chgs_pkg::OFS_EVT_MASK:    REG_RDATA <= evt_mask_reg;
                default:                   REG_RDATA <= 8'h00;
            endcase
        end
        else
            REG_RDATA <= 8'h00;
    end

    // decoded set points, registered so outputs come from flops
    logic [12:0] vbat_d;
    logic [12:0] fast_charge_current_code_d;
    logic [12:0] end_of_charge_threshold_d;
    logic [12:0] weak_battery_current_d;
    logic [12:0] recon_d;
    logic [12:0] iin_d;

    chgs_decode u_decode (
        .vbat_code                   (vbat_reg[5:0]),
        .fast_charge_current_code    (chg_reg[3:0]),
        .charge_current_range_extend (chg_reg[chgs_pkg::CHG_EXT_BIT]),
        .end_of_charge_threshold     (chg_reg[chgs_pkg::EOC_LSB +: 3]),
        .weak_battery_current        (weak_reg[chgs_pkg::WEAK_LSB +: 2]),
        .reconnect_threshold         (weak_reg[chgs_pkg::RECON_LSB +: 3]),
        .input_limit_code            (weak_reg[1:0]),
        .adapter_limit_code          (adapter_reg[chgs_pkg::ADAPTER_LSB +: 4]),
        .vbat_mv                     (vbat_d),
        .fast_charge_current_code_ma                     (fast_charge_current_code_d),
        .end_of_charge_threshold_ma                     (end_of_charge_threshold_d),
        .weak_battery_current_ma                    (weak_battery_current_d),
        .recon_mv                    (recon_d),
        .iin_ma                      (iin_d)
    );

    // set point outputs follow the registers one cycle later
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            VBAT_MV  <= 13'h0000;
            FAST_CHARGE_CURRENT_CODE_MA  <= 13'h0000;
            END_OF_CHARGE_THRESHOLD_MA  <= 13'h0000;
            WEAK_BATTERY_CURRENT_MA <= 13'h0000;
            RECON_MV <= 13'h0000;
            IIN_MA   <= 13'h0000;
        end
        else
        begin
            VBAT_MV  <= vbat_d;
            FAST_CHARGE_CURRENT_CODE_MA  <= fast_charge_current_code_d;
            END_OF_CHARGE_THRESHOLD_MA  <= end_of_charge_threshold_d;
            WEAK_BATTERY_CURRENT_MA <= weak_battery_current_d;
            RECON_MV <= recon_d;
            IIN_MA   <= iin_d;
        end
    end

    // checks
    vbat_track_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> VBAT_MV == 13'd3300 + 13'($past(vbat_reg[5:0])) * 13'd25)
        else $error("battery target decode wrong");
    chg_track_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && !$past(chg_reg[7]) |->
        FAST_CHARGE_CURRENT_CODE_MA == 13'd450 + 13'($past(chg_reg[3:0])) * 13'd100)
        else $error("charge current decode wrong");
    chg_extend_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $past(chg_reg[7]) |-> FAST_CHARGE_CURRENT_CODE_MA == 13'd2050 + 13'($past(chg_reg[3:0])) * 13'd100)
        else $error("range extension missing");
    eoc_track_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> END_OF_CHARGE_THRESHOLD_MA == 13'd100 + 13'($past(chg_reg[6:4])) * 13'd25)
        else $error("end of charge decode wrong");
    weak_track_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> WEAK_BATTERY_CURRENT_MA == 13'($past(weak_reg[6:5])) * 13'd100)
        else $error("weak current decode wrong");
    recon_track_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && $past(weak_reg[4:2]) <= 3'h5 |->
        RECON_MV == 13'd3100 + 13'($past(weak_reg[4:2])) * 13'd100)
        else $error("reconnect decode wrong");
    inlim_usb_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $past(adapter_reg[7:4]) == 4'h0 && $past(weak_reg[1:0]) == 2'h3 |-> IIN_MA == 13'd1500)
        else $error("input limit decode wrong");
    inlim_adapter_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $past(adapter_reg[7:4]) != 4'h0 |->
        IIN_MA == 13'd500 + 13'($past(adapter_reg[7:4])) * 13'd100)
        else $error("adapter limit decode wrong");
    defaults_load_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        defaults |=> vbat_reg == 8'h0C && chg_reg == 8'h26 && boost_mask_reg == 8'h1F)
        else $error("defaults not restored");
    mask_block_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (evt_status_reg[5:0] & evt_gate) == 6'h00 ##1
        (evt_status_reg[5:0] & evt_gate) == 6'h00 |-> !IRQ)
        else $error("masked event raised interrupt");
    reserved_zero_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        vbat_reg[7:6] == 2'h0 && weak_reg[7] == 1'b0 && adapter_reg[3:0] == 4'h0)
        else $error("reserved bit stored");

    // mask registers keep their reserved bits clear as well
    mask_reserved_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        timer_mask_reg[7:2] == 6'h00 && timer_mask_reg[0] == 1'b0
        && boost_mask_reg[7:5] == 3'h0 && evt_mask_reg[7:6] == 2'h0
        && evt_status_reg[7:6] == 2'h0)
        else $error("reserved mask bit stored");

    // read data stands only in the cycle after a read strobe
    rdata_idle_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");

    // unmapped addresses read as zero
    rdata_unmapped_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $past(REG_RD) && $past(REG_ADDR) > chgs_pkg::OFS_EVT_MASK |-> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");

    // the battery target readback never shows its reserved bits
    rdata_vbat_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $past(REG_RD) && $past(REG_ADDR) == chgs_pkg::OFS_VBAT_TARGET
        |-> REG_RDATA[7:6] == 2'h0)
        else $error("reserved target bits read back");

    // a write outside any restore lands whole in the charge register
    chg_write_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && !$past(defaults) && $past(REG_WR)
        && $past(REG_ADDR) == chgs_pkg::OFS_CHG_CURRENT
        |-> chg_reg == $past(REG_WDATA))
        else $error("charge register write lost");

    // every other setting and mask also reloads its default
    defaults_rest_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        defaults |=> weak_reg == 8'h2C && adapter_reg == 8'h00
        && timer_mask_reg == 8'h02 && evt_mask_reg == 8'h00)
        else $error("remaining defaults not restored");

    // undefined reconnect codes hold the top threshold
    recon_clamp_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && $past(weak_reg[4:2]) > 3'h5 |-> RECON_MV == 13'd3600)
        else $error("reconnect clamp wrong");

    // full two-bit input limit table while the adapter field defers
    inlim_table_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && $past(adapter_reg[7:4]) == 4'h0 |->
        IIN_MA == ($past(weak_reg[1]) ? ($past(weak_reg[0]) ? 13'd1500 : 13'd900)
                                      : ($past(weak_reg[0]) ? 13'd500 : 13'd100)))
        else $error("input limit table wrong");

    // interrupt follows the unmasked status whenever the gate is steady
    irq_level_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) && $stable(evt_gate)
        |-> IRQ == |(evt_status_reg[5:0] & evt_gate))
        else $error("interrupt level wrong");

    // status bits stay set until software writes ones to them
    status_sticky_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST)
        && !($past(REG_WR) && $past(REG_ADDR) == chgs_pkg::OFS_EVT_STATUS)
        |-> (evt_status_reg & $past(evt_status_reg)) == $past(evt_status_reg))
        else $error("status bit dropped");

    // every detected edge sets its status bit, even against a clear
    status_set_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> (evt_status_reg[5:0] & $past(evt_rise)) == $past(evt_rise))
        else $error("event not recorded");
endmodule
`default_nettype wire

//--- tb/chgs_host.sv
// host processor model that reaches the setting registers over the plain port
`timescale 1ns/1ps
`default_nettype none
module chgs_host (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // read data of the last read
    output logic      [7:0] rdata_seen
);
    // idle bus; address is inverted after each access, and data after each write, so stale values never look valid
    initial
    begin
        reg_addr   = 8'h3C;
        reg_wdata  = 8'hC3;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        rdata_seen = 8'h00;
    end

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // one-cycle read strobe; data stands only in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        rdata_seen = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the charger setting register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [7:0]  rv;
    logic        off_state;
    logic        reset_cmd;
    logic        boost_mode;
    logic [5:0]  evt;
    logic [12:0] vbat_mv, fast_charge_current_code_ma, end_of_charge_threshold_ma, weak_battery_current_ma, recon_mv, iin_ma;
    logic        irq;
    int          n_mismatch;
    int          n_tests;
    int          k;
    int          c;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    chgs_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rdata_seen(rv));

    chgs_regs u_dut (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .OFF_STATE(off_state),
        .REG_RESET_CMD(reset_cmd), .BOOST_HOST_MODE(boost_mode), .EVT_IN(evt),
        .VBAT_MV(vbat_mv), .FAST_CHARGE_CURRENT_CODE_MA(fast_charge_current_code_ma), .END_OF_CHARGE_THRESHOLD_MA(end_of_charge_threshold_ma), .WEAK_BATTERY_CURRENT_MA(weak_battery_current_ma),
        .RECON_MV(recon_mv), .IIN_MA(iin_ma), .IRQ(irq));

    // comparison helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a);
        check("read data", {8'h00, rv}, {8'h00, exp});
    endtask
    // set points lag the registers by one cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    function automatic int rcn(input int code);
        return (code > 5) ? 3600 : 3100 + 100 * code;
    endfunction
    function automatic int iin_tab(input int code);
        return (code == 0) ? 100 : (code == 1) ? 500 : (code == 2) ? 900 : 1500;
    endfunction

    // every setting and mask except the event mask back at its listed default
    task automatic chk_defaults();
        rchk(chgs_pkg::OFS_TIMER_MASK, 8'h02);
        rchk(chgs_pkg::OFS_BOOST_MASK, 8'h1F);
        rchk(chgs_pkg::OFS_VBAT_TARGET, 8'h0C);
        rchk(chgs_pkg::OFS_CHG_CURRENT, 8'h26);
        rchk(chgs_pkg::OFS_WEAK_INLIM, 8'h2C);
        rchk(chgs_pkg::OFS_ADAPTER_LIM, 8'h00);
        settle();
        check("battery target", vbat_mv, 16'd3600);
        check("charge current", fast_charge_current_code_ma, 16'd1050);
        check("end of charge", end_of_charge_threshold_ma, 16'd150);
        check("weak current", weak_battery_current_ma, 16'd100);
        check("reconnect", recon_mv, 16'd3400);
        check("input limit", iin_ma, 16'd100);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    // main sequence
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        off_state = 1'b0;
        reset_cmd = 1'b0;
        boost_mode = 1'b0;
        evt = 6'h00;
        n_mismatch = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk_defaults();
        rchk(chgs_pkg::OFS_EVT_MASK, 8'h00);
        u_host.wr(8'h20, 8'hA5);
        rchk(8'h20, 8'h00);
        @(posedge clk);
        #1;
        check("idle read data", {8'h00, reg_rdata}, 16'h0000);
        for (k = 0; k < 49; k++)
        begin
            u_host.wr(chgs_pkg::OFS_VBAT_TARGET, {2'b11, 6'(k)});
            settle();
            check("battery target", vbat_mv, 16'(3300 + 25 * k));
        end
        rchk(chgs_pkg::OFS_VBAT_TARGET, 8'h30);
        for (k = 0; k < 256; k++)
        begin
            u_host.wr(chgs_pkg::OFS_CHG_CURRENT, 8'(k));
            settle();
            check("charge current", fast_charge_current_code_ma, 16'(450 + 100 * (k % 16) + (k / 128) * 1600));
            check("end of charge", end_of_charge_threshold_ma, 16'(100 + 25 * ((k / 16) % 8)));
        end
        rchk(chgs_pkg::OFS_CHG_CURRENT, 8'hFF);
        for (k = 0; k < 256; k++)
        begin
            u_host.wr(chgs_pkg::OFS_WEAK_INLIM, 8'(k));
            rchk(chgs_pkg::OFS_WEAK_INLIM, 8'(k % 128));
            settle();
            check("weak current", weak_battery_current_ma, 16'(100 * ((k / 32) % 4)));
            check("reconnect", recon_mv, 16'(rcn((k / 4) % 8)));
            check("input limit", iin_ma, 16'(iin_tab(k % 4)));
        end
        u_host.wr(chgs_pkg::OFS_WEAK_INLIM, 8'h2E);
        for (k = 0; k < 16; k++)
        begin
            u_host.wr(chgs_pkg::OFS_ADAPTER_LIM, {4'(k), 4'hF});
            rchk(chgs_pkg::OFS_ADAPTER_LIM, {4'(k), 4'h0});
            settle();
            check("adapter limit", iin_ma, 16'((k == 0) ? 900 : 500 + 100 * k));
        end
        // each restoring condition in turn; writes during off state or reset command are lost
        for (c = 0; c < 4; c++)
        begin
            for (k = 12; k < 17; k++)
                u_host.wr(8'(k), 8'h00);
            u_host.wr(chgs_pkg::OFS_ADAPTER_LIM, 8'hFF);
            @(posedge clk);
            off_state <= (c == 0);
            reset_cmd <= (c == 1);
            boost_mode <= (c == 2);
            rst <= (c == 3);
            repeat (10) @(posedge clk);
            if (c < 2)
                u_host.wr(chgs_pkg::OFS_VBAT_TARGET, 8'h01);
            off_state <= 1'b0;
            reset_cmd <= 1'b0;
            boost_mode <= 1'b0;
            rst <= 1'b0;
            repeat (5) @(posedge clk);
            chk_defaults();
        end
        // events: masked by default, then unmasked one at a time
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk);
            evt <= 6'(1 << k);
            repeat (4) @(posedge clk);
            #1;
            check("masked interrupt", {15'h0, irq}, 16'h0000);
            rchk(chgs_pkg::OFS_EVT_STATUS, 8'(1 << k));
            if (k == 5)
                u_host.wr(chgs_pkg::OFS_TIMER_MASK, 8'h00);
            else
                u_host.wr(chgs_pkg::OFS_BOOST_MASK, 8'h1F & ~8'(1 << k));
            settle();
            check("unmasked interrupt", {15'h0, irq}, 16'h0001);
            u_host.wr(chgs_pkg::OFS_EVT_STATUS, 8'(1 << k));
            settle();
            check("cleared interrupt", {15'h0, irq}, 16'h0000);
            rchk(chgs_pkg::OFS_EVT_STATUS, 8'h00);
            u_host.wr(chgs_pkg::OFS_TIMER_MASK, 8'h02);
            u_host.wr(chgs_pkg::OFS_BOOST_MASK, 8'h1F);
            @(posedge clk);
            evt <= 6'h00;
        end
        conclude();
    end
endmodule
`default_nettype wire
